// ==== design/lcrseq_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcrseq_regs.svh"
module lcrseq_top (
   input  wire logic                 mclk,
   input  wire logic                 nrst,
   input  wire logic                 state_clk_en,
   input  wire logic                 panel_reset,
   input  wire lcrseq_pkg::lcrseq_cfg_t  cfg,
   input  wire lcrseq_pkg::lcrseq_stat_t stat,
   output logic [`LCRSEQ_CODE_W-1:0] state_code,
   output logic                      state_strobe
);
   import lcrseq_pkg::*;

   localparam int SYNC_W = $bits(lcrseq_cfg_t) + $bits(lcrseq_stat_t) + 1;

   logic [SYNC_W-1:0]         sync_q;
   lcrseq_cfg_t               cfg_s;
   lcrseq_stat_t              stat_s;
   logic                      rst_s;
   logic                      rst_d_r;
   logic [`LCRSEQ_CODE_W-1:0] code_r;
   logic [`LCRSEQ_CODE_W-1:0] code_nxt;
   logic                      strobe_nxt;
   logic                      auto_r;
   logic                      auto_nxt;

   // Panel settings and analogue status are asynchronous to the state clock.
   lcrseq_sync #(
      .W (SYNC_W)
   ) u_sync (
      .mclk (mclk),
      .nrst (nrst),
      .d    ({panel_reset, cfg, stat}),
      .q    (sync_q)
   );
   assign {rst_s, cfg_s, stat_s} = sync_q;

   wire reset_edge = rst_s && !rst_d_r;

   // Branch choice after the initial setup states: self-test (011) or model selection (037).
   function automatic logic [`LCRSEQ_CODE_W-1:0] after_setup(input lcrseq_cfg_t c);
      if (c.test != TEST_NONE)
         after_setup = `LCRSEQ_S011;
      else
         after_setup = `LCRSEQ_S037;
   endfunction

   always_comb begin
      code_nxt   = code_r;
      auto_nxt   = auto_r;
      strobe_nxt = 1'b0;
      if (reset_edge) begin
         code_nxt   = `LCRSEQ_S001;
         auto_nxt   = 1'b0;
         strobe_nxt = 1'b1;
      end else if (state_clk_en) begin
         strobe_nxt = 1'b1;
         // One step per state clock; the conditional branches read the synchronized cfg_s and stat_s.
         unique case (code_r)
            `LCRSEQ_S010: code_nxt = after_setup(cfg_s);
            `LCRSEQ_S011: code_nxt = `LCRSEQ_S012;
            `LCRSEQ_S012: begin
               if (cfg_s.test == TEST_TWO)
                  code_nxt = `LCRSEQ_S031;
               else
                  code_nxt = `LCRSEQ_S013;
            end
            `LCRSEQ_S031: begin
               if (cfg_s.range_hold)
                  code_nxt = `LCRSEQ_S033;
               else
                  code_nxt = `LCRSEQ_S032;
            end
            `LCRSEQ_S032: code_nxt = `LCRSEQ_S034;
            `LCRSEQ_S033: code_nxt = `LCRSEQ_S034;
            `LCRSEQ_S034: begin
               if (cfg_s.range_hold)
                  code_nxt = `LCRSEQ_S035;
               else
                  code_nxt = `LCRSEQ_S036;
            end
            `LCRSEQ_S036: code_nxt = `LCRSEQ_S035;
            `LCRSEQ_S035: code_nxt = `LCRSEQ_S013;
            `LCRSEQ_S037: begin
               auto_nxt = (cfg_s.model == MODEL_AUTO);
               if (cfg_s.model == MODEL_AUTO)
                  code_nxt = `LCRSEQ_S042;
               else
                  code_nxt = `LCRSEQ_S040;
            end
            `LCRSEQ_S040: begin
               if (cfg_s.model == SERIES_MODEL)
                  code_nxt = `LCRSEQ_S055;
               else
                  code_nxt = `LCRSEQ_S041;
            end
            `LCRSEQ_S041: code_nxt = `LCRSEQ_S035;
            `LCRSEQ_S042: code_nxt = `LCRSEQ_S043;
            `LCRSEQ_S043: begin
               if (cfg_s.func == FUNC_C && stat_s.open_unk)
                  code_nxt = `LCRSEQ_S046;
               else if (cfg_s.func == FUNC_R && stat_s.short_unk)
                  code_nxt = `LCRSEQ_S046;
               else
                  code_nxt = `LCRSEQ_S044;
            end
            `LCRSEQ_S044: begin
               if (stat_s.in_range)
                  code_nxt = `LCRSEQ_S045;
               else
                  code_nxt = `LCRSEQ_S051;
            end
            `LCRSEQ_S045: code_nxt = `LCRSEQ_S013;
            `LCRSEQ_S046: begin
               if (stat_s.short_unk)
                  code_nxt = `LCRSEQ_S052;
               else
                  code_nxt = `LCRSEQ_S047;
            end
            `LCRSEQ_S051: begin
               if (stat_s.short_unk)
                  code_nxt = `LCRSEQ_S052;
               else
                  code_nxt = `LCRSEQ_S047;
            end
            `LCRSEQ_S047: code_nxt = `LCRSEQ_S050;
            `LCRSEQ_S050: code_nxt = `LCRSEQ_S013;
            `LCRSEQ_S052: code_nxt = `LCRSEQ_S013;
            `LCRSEQ_S055: code_nxt = `LCRSEQ_S035;
            `LCRSEQ_S013: code_nxt = `LCRSEQ_S013;
            `LCRSEQ_S000: code_nxt = `LCRSEQ_S000;
            default: begin
               // Setup states 001 to 007 simply count upward.
               if (code_r >= `LCRSEQ_S001 && code_r < `LCRSEQ_S010)
                  code_nxt = code_r + 7'h01;
               else
                  code_nxt = `LCRSEQ_S000;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         code_r       <= `LCRSEQ_S000;
         auto_r       <= 1'b0;
         rst_d_r      <= 1'b0;
         state_code   <= `LCRSEQ_S000;
         state_strobe <= 1'b0;
      end else begin
         code_r       <= code_nxt;
         auto_r       <= auto_nxt;
         rst_d_r      <= rst_s;
         state_code   <= code_nxt;
         state_strobe <= strobe_nxt;
      end
   end

   property setup_ascends_p;
      @(posedge mclk) disable iff (!nrst)
      (state_clk_en && !reset_edge && code_r >= `LCRSEQ_S001 && code_r < `LCRSEQ_S010)
         |=> (code_r == $past(code_r) + 7'h01);
   endproperty
   setup_ascend_a: assert property (setup_ascends_p) else $error("setup not ascending");

   reset_start_a: assert property (@(posedge mclk) disable iff (!nrst)
      reset_edge |=> state_code == `LCRSEQ_S001) else $error("reset did not give 001");

   output_match_a: assert property (@(posedge mclk) disable iff (!nrst)
      (state_clk_en || reset_edge) |=> state_strobe && state_code == code_r)
      else $error("state output differs");

   one_step_a: assert property (@(posedge mclk) disable iff (!nrst)
      (!state_clk_en && !reset_edge) |=> $stable(code_r) && !state_strobe)
      else $error("moved without clock");

   test1_path_a: assert property (@(posedge mclk) disable iff (!nrst)
      (state_clk_en && !reset_edge && code_r == `LCRSEQ_S012 && cfg_s.test == TEST_ONE)
         |=> code_r == `LCRSEQ_S013) else $error("test one path wrong");

   test2_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      (state_clk_en && !reset_edge && code_r == `LCRSEQ_S031 && cfg_s.range_hold)
         |=> code_r == `LCRSEQ_S033) else $error("test two path wrong");

   auto_entry_a: assert property (@(posedge mclk) disable iff (!nrst)
      (state_clk_en && !reset_edge && code_r == `LCRSEQ_S037 && cfg_s.model == MODEL_AUTO)
         |=> code_r == `LCRSEQ_S042 && auto_r) else $error("auto entry wrong");

   short_exit_a: assert property (@(posedge mclk) disable iff (!nrst)
      (state_clk_en && !reset_edge && code_r == `LCRSEQ_S051 && stat_s.short_unk)
         |=> code_r == `LCRSEQ_S052) else $error("short branch wrong");

   mid_range_a: assert property (@(posedge mclk) disable iff (!nrst)
      (state_clk_en && !reset_edge && code_r == `LCRSEQ_S044 && stat_s.in_range)
         |=> code_r == `LCRSEQ_S045) else $error("in-range branch wrong");

   r_short_a: assert property (@(posedge mclk) disable iff (!nrst)
      (state_clk_en && !reset_edge && code_r == `LCRSEQ_S046 && stat_s.short_unk)
         |=> code_r == `LCRSEQ_S052) else $error("resistance short wrong");

   // Multi-step paths are split into a leaving step and a landing step, so a wrong
   // middle state is caught at the very state clock where it happens.
   sequence test_leave_setup_s;
      state_clk_en && !reset_edge && code_r == `LCRSEQ_S010 && cfg_s.test != TEST_NONE;
   endsequence

   sequence test_land_s;
      state_strobe && code_r == `LCRSEQ_S011;
   endsequence

   test_entry_a: assert property (@(posedge mclk) disable iff (!nrst)
      test_leave_setup_s |=> test_land_s) else $error("self-test entry wrong");

   sequence hold_leave_s;
      state_clk_en && !reset_edge && code_r == `LCRSEQ_S034 && cfg_s.range_hold;
   endsequence

   sequence hold_land_s;
      state_strobe && code_r == `LCRSEQ_S035;
   endsequence

   hold_end_a: assert property (@(posedge mclk) disable iff (!nrst)
      hold_leave_s |=> hold_land_s) else $error("test two hold exit wrong");

   cap_open_a: assert property (@(posedge mclk) disable iff (!nrst)
      (state_clk_en && !reset_edge && code_r == `LCRSEQ_S043 && cfg_s.func == FUNC_C
         && stat_s.open_unk) |=> code_r == `LCRSEQ_S046) else $error("open capacitor wrong");
endmodule
`default_nettype wire

// ==== design/lcrseq_regs.svh ====
`ifndef LCRSEQ_REGS_SVH
`define LCRSEQ_REGS_SVH
`define LCRSEQ_CODE_W 7
`define LCRSEQ_S001 7'h01
`define LCRSEQ_S010 7'h08
`define LCRSEQ_S011 7'h09
`define LCRSEQ_S012 7'h0A
`define LCRSEQ_S013 7'h0B
`define LCRSEQ_S031 7'h19
`define LCRSEQ_S032 7'h1A
`define LCRSEQ_S033 7'h1B
`define LCRSEQ_S034 7'h1C
`define LCRSEQ_S035 7'h1D
`define LCRSEQ_S036 7'h1E
`define LCRSEQ_S037 7'h1F
`define LCRSEQ_S040 7'h20
`define LCRSEQ_S041 7'h21
`define LCRSEQ_S042 7'h22
`define LCRSEQ_S043 7'h23
`define LCRSEQ_S044 7'h24
`define LCRSEQ_S045 7'h25
`define LCRSEQ_S046 7'h26
`define LCRSEQ_S047 7'h27
`define LCRSEQ_S050 7'h28
`define LCRSEQ_S051 7'h29
`define LCRSEQ_S052 7'h2A
`define LCRSEQ_S053 7'h2B
`define LCRSEQ_S054 7'h2C
`define LCRSEQ_S055 7'h2D
`define LCRSEQ_S000 7'h00
`endif

// ==== design/lcrseq_pkg.sv ====
package lcrseq_pkg;
   typedef enum logic [1:0] {
      FUNC_R = 2'h0,
      FUNC_C = 2'h1,
      FUNC_L = 2'h2
   } lcrseq_func_t;
   typedef enum logic [1:0] {
      MODEL_AUTO     = 2'h0,
      PARALLEL_MODEL = 2'h1,
      SERIES_MODEL   = 2'h2
   } lcrseq_model_t;
   typedef enum logic [1:0] {
      TEST_NONE = 2'h0,
      TEST_ONE  = 2'h1,
      TEST_TWO  = 2'h2
   } lcrseq_test_t;
   typedef struct packed {
      lcrseq_func_t  func;
      lcrseq_model_t model;
      lcrseq_test_t  test;
      logic          range_hold;
      logic          external_trigger;
   } lcrseq_cfg_t;
   typedef struct packed {
      logic open_unk;
      logic short_unk;
      logic in_range;
   } lcrseq_stat_t;
endpackage

// ==== design/lcrseq_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcrseq_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ==== tb/lcrseq_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcrseq_panel_model (
   input  wire lcrseq_pkg::lcrseq_func_t  func,
   input  wire lcrseq_pkg::lcrseq_model_t model,
   input  wire lcrseq_pkg::lcrseq_test_t  test,
   input  wire logic                      hold_on,
   input  wire logic [1:0]                unk,
   output lcrseq_pkg::lcrseq_cfg_t        cfg,
   output lcrseq_pkg::lcrseq_stat_t       stat
);
   import lcrseq_pkg::*;
   // Unknown codes: 0 open, 1 shorted, 2 in range, 3 no status flag set.
   always_comb begin
      cfg.func             = func;
      cfg.model            = model;
      cfg.test             = test;
      cfg.range_hold       = hold_on;
      cfg.external_trigger = 1'b0;
      stat.open_unk        = (unk == 2'h0);
      stat.short_unk       = (unk == 2'h1);
      stat.in_range        = (unk == 2'h2);
   end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcrseq_regs.svh"
module tb_top;
   import lcrseq_pkg::*;
   typedef logic [`LCRSEQ_CODE_W-1:0] lcrseq_code_q_t[$];
   logic                      mclk;
   logic                      nrst;
   logic                      state_clk_en;
   logic                      panel_reset;
   lcrseq_func_t              func;
   lcrseq_model_t             model;
   lcrseq_test_t              test;
   logic                      hold_on;
   logic [1:0]                unk;
   lcrseq_cfg_t               cfg;
   lcrseq_stat_t              stat;
   logic [`LCRSEQ_CODE_W-1:0] state_code;
   logic                      state_strobe;
   int                        fail_count;
   int                        tests_run;

   lcrseq_panel_model lcrseq_panel_model_inst (.func(func), .model(model), .test(test),
      .hold_on(hold_on), .unk(unk), .cfg(cfg), .stat(stat));
   lcrseq_top lcrseq_top_inst (.mclk(mclk), .nrst(nrst), .state_clk_en(state_clk_en),
      .panel_reset(panel_reset), .cfg(cfg), .stat(stat), .state_code(state_code),
      .state_strobe(state_strobe));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %o seen %o", what, exp, got);
      end
   endtask

   // The strobe is a one-cycle pulse, so it is looked for at each of up to four falling edges.
   task automatic step_once(output logic seen);
      @(posedge mclk) state_clk_en <= 1'b1;
      @(posedge mclk) state_clk_en <= 1'b0;
      seen = 1'b0;
      for (int i = 0; i < 4 && !seen; i++) begin
         @(negedge mclk);
         seen = (state_strobe === 1'b1);
      end
   endtask

   task automatic run_path(input lcrseq_func_t f, input lcrseq_model_t m, input lcrseq_test_t t,
                           input logic h, input logic [1:0] u, input lcrseq_code_q_t tail);
      logic seen;
      @(posedge mclk);
      func <= f;
      model <= m;
      test <= t;
      hold_on <= h;
      unk <= u;
      repeat (6) @(posedge mclk);
      panel_reset <= 1'b1;
      seen = 1'b0;
      for (int i = 0; i < 8 && !seen; i++) begin
         @(negedge mclk);
         seen = (state_strobe === 1'b1);
      end
      check("restart strobe", 7'h01, {6'h00, seen});
      check("restart code", `LCRSEQ_S001, state_code);
      @(posedge mclk) panel_reset <= 1'b0;
      repeat (4) @(negedge mclk);
      check("held code", `LCRSEQ_S001, state_code);
      check("held strobe", 7'h00, {6'h00, state_strobe});
      for (int i = 1; i < 8; i++) begin
         step_once(seen);
         check("setup strobe", 7'h01, {6'h00, seen});
         check("setup code", `LCRSEQ_S001 + 7'(i), state_code);
      end
      if (t == TEST_NONE && m == MODEL_AUTO) begin
         tail = {`LCRSEQ_S037, `LCRSEQ_S042, `LCRSEQ_S043, tail};
      end
      foreach (tail[k]) begin
         step_once(seen);
         check("branch strobe", 7'h01, {6'h00, seen});
         check("branch code", tail[k], state_code);
      end
      step_once(seen);
      check("terminal code", `LCRSEQ_S013, state_code);
   endtask

   task automatic cap_open;
      run_path(FUNC_C, MODEL_AUTO, TEST_NONE, 1'b0, 2'h0,
               '{`LCRSEQ_S046, `LCRSEQ_S047, `LCRSEQ_S050, `LCRSEQ_S013});
   endtask

   task automatic cap_short;
      run_path(FUNC_C, MODEL_AUTO, TEST_NONE, 1'b0, 2'h1,
               '{`LCRSEQ_S044, `LCRSEQ_S051, `LCRSEQ_S052, `LCRSEQ_S013});
   endtask

   task automatic res_short;
      run_path(FUNC_R, MODEL_AUTO, TEST_NONE, 1'b0, 2'h1,
               '{`LCRSEQ_S046, `LCRSEQ_S052, `LCRSEQ_S013});
   endtask

   task automatic ind_open;
      run_path(FUNC_L, MODEL_AUTO, TEST_NONE, 1'b0, 2'h0,
               '{`LCRSEQ_S044, `LCRSEQ_S051, `LCRSEQ_S047, `LCRSEQ_S050, `LCRSEQ_S013});
   endtask

   task automatic ind_in_range;
      run_path(FUNC_L, MODEL_AUTO, TEST_NONE, 1'b0, 2'h2,
               '{`LCRSEQ_S044, `LCRSEQ_S045, `LCRSEQ_S013});
   endtask

   task automatic self_test_one;
      run_path(FUNC_C, MODEL_AUTO, TEST_ONE, 1'b0, 2'h3,
               '{`LCRSEQ_S011, `LCRSEQ_S012, `LCRSEQ_S013});
   endtask

   task automatic self_test_two;
      run_path(FUNC_L, MODEL_AUTO, TEST_TWO, 1'b1, 2'h3, '{`LCRSEQ_S011, `LCRSEQ_S012,
               `LCRSEQ_S031, `LCRSEQ_S033, `LCRSEQ_S034, `LCRSEQ_S035, `LCRSEQ_S013});
   endtask

   task automatic parallel_model_model;
      run_path(FUNC_C, PARALLEL_MODEL, TEST_NONE, 1'b0, 2'h3,
               '{`LCRSEQ_S037, `LCRSEQ_S040, `LCRSEQ_S041, `LCRSEQ_S035, `LCRSEQ_S013});
   endtask

   task automatic series_model;
      run_path(FUNC_C, SERIES_MODEL, TEST_NONE, 1'b0, 2'h3,
               '{`LCRSEQ_S037, `LCRSEQ_S040, `LCRSEQ_S055, `LCRSEQ_S035, `LCRSEQ_S013});
   endtask

   task automatic self_test_two_free;
      run_path(FUNC_C, MODEL_AUTO, TEST_TWO, 1'b0, 2'h3, '{`LCRSEQ_S011, `LCRSEQ_S012,
               `LCRSEQ_S031, `LCRSEQ_S032, `LCRSEQ_S034, `LCRSEQ_S036, `LCRSEQ_S035,
               `LCRSEQ_S013});
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      $display("[ERR] run length expected done seen hang");
      wrap_up();
   end

   initial begin
      nrst = 1'b0;
      state_clk_en = 1'b0;
      panel_reset = 1'b0;
      func = FUNC_C;
      model = MODEL_AUTO;
      test = TEST_NONE;
      hold_on = 1'b0;
      unk = 2'h3;
      fail_count = 0;
      tests_run = 0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(negedge mclk);
      check("idle code", `LCRSEQ_S000, state_code);
      cap_open();
      cap_short();
      res_short();
      ind_open();
      ind_in_range();
      self_test_one();
      self_test_two();
      parallel_model_model();
      series_model();
      self_test_two_free();
      wrap_up();
   end
endmodule
`default_nettype wire
